// *** logic/wdrs_params.svh ***
// Constants of the watchdog and reset sequencer: offsets, bit positions, reset values, timings.
// Assumes inclusion by bare name from files under logic/.
`ifndef WDRS_PARAMS_SVH
`define WDRS_PARAMS_SVH

`define WDRS_ADDR_CTRL 8'h00
`define WDRS_ADDR_FLAGS 8'h01
`define WDRS_ADDR_CMP 8'h02

`define WDRS_CTRL_IF 7
`define WDRS_CTRL_IE 6
`define WDRS_CTRL_P3 5
`define WDRS_CTRL_CE 4
`define WDRS_CTRL_RE 3

`define WDRS_FLAG_POR 0
`define WDRS_FLAG_EXT 1
`define WDRS_FLAG_BOD 2
`define WDRS_FLAG_WD 3
`define WDRS_CMP_BG 0

`define WDRS_FLAGS_RESET 4'h1
`define WDRS_UNLOCK_CYCLES 3'h4
`define WDRS_WD_BASE_CYCLES 2048
`define WDRS_WD_MAX_CODE 4'h9

`define WDRS_CLK_PERIOD_NS 50
`define WDRS_BOD_MIN_NS 2000
`define WDRS_BOD_MIN_CYCLES ((`WDRS_BOD_MIN_NS + `WDRS_CLK_PERIOD_NS - 1) / `WDRS_CLK_PERIOD_NS)
`define WDRS_RST_DELAY_US 4100
`define WDRS_RST_DELAY_CYCLES ((`WDRS_RST_DELAY_US * 1000 + `WDRS_CLK_PERIOD_NS - 1) / `WDRS_CLK_PERIOD_NS)

`endif

// *** logic/wdrs_pkg.sv ***
// Types of the watchdog and reset sequencer.
// Assumes wdrs_params.svh supplies every number.
`default_nettype none

package wdrs_pkg;

   typedef struct packed {
      logic irqFlag;
      logic irqEn;
      logic resetEn;
      logic [3:0] prescale;
      logic [2:0] unlockCnt;
      logic [3:0] rstFlags;
      logic cmpBandgapSel;
      logic [2:0] oscSync;
      logic [20:0] wdCount;
      logic [5:0] bodCnt;
      logic [19:0] delayCnt;
      logic delayBusy;
      logic wdPulse;
      logic bandgapEn;
      logic [7:0] rdata;
   } wdrs_state_t;

endpackage : wdrs_pkg

`default_nettype wire

// *** logic/wdrs_watchdog_and_reset_sequencer.sv ***
// Watchdog timer and system reset sequencer, one clock domain at 20 MHz.
// Assumes the watchdog oscillator arrives as a plain level on wdOscClk and is sampled here.
// Function
// - Low supply resets at once, then delay
// - Long external pin low resets without clock
// - Disable fuse makes external pin ignored
// - Brown-out resets, releases after delay time-out
// - Brown-out glitches below minimum duration ignored
// - Watchdog reset is one-cycle pulse, then delay
// - Bandgap on for brown-out, comparator, converter
// - Watchdog counts the separate oscillator
// - Restart clears counter; missed restart acts
// - Interrupt mode raises wake-capable interrupt
// - Reset mode resets on expiry
// - Combined mode: interrupt first, then reset
// - Always-on fuse forces reset mode bits
// - Protected changes accepted only in window
// - Watchdog keeps counting in every sleep mode
// - Periods selectable from 16ms to 8s
// - Watchdog stays enabled after watchdog reset
// - Reset flag forces reset-enable high
// - Change-enable clears four cycles after set
// - Prescale code n up to 9 selects 2048 shl n
// - Vector service clears flag, combined clears enable
`timescale 1ns/1ps
`include "wdrs_params.svh"
`default_nettype none

module wdrs_watchdog_and_reset_sequencer #(
   parameter int unsigned DelayCycles = `WDRS_RST_DELAY_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic porLow,
   input wire logic extResetPin_b,
   input wire logic extResetDisableFuse,
   input wire logic brownoutEnable,
   input wire logic brownoutLow,
   input wire logic watchdogAlwaysOnFuse,
   input wire logic adcEnable,
   input wire logic wdOscClk,
   input wire logic wdRestart,
   input wire logic irqAck,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic sysReset,
   output logic wdIrq,
   output logic bandgapEnable
);

   localparam logic [5:0] BodMin = 6'(`WDRS_BOD_MIN_CYCLES);
   localparam logic [19:0] DelayLast = 20'(DelayCycles - 1);

   wdrs_pkg::wdrs_state_t s_q;
   wdrs_pkg::wdrs_state_t s_d;

   logic tick;
   logic bodTrip;
   logic extTrip;
   logic srcActive;
   logic effRe;
   logic effIe;
   logic running;
   logic expire;
   logic resetReq;
   logic ctrlWr;
   logic [3:0] code;
   logic [20:0] limit;

   always_comb begin
      s_d = s_q;
      // A rising oscillator edge is seen only after two sampling stages.
      s_d.oscSync = {s_q.oscSync[1:0], wdOscClk};
      tick = s_q.oscSync[1] & ~s_q.oscSync[2];

      // Brown-out low must persist before it counts as a reset source.
      if (brownoutEnable && brownoutLow) begin
         if (s_q.bodCnt < BodMin) begin
            s_d.bodCnt = s_q.bodCnt + 6'h01;
         end
      end else begin
         s_d.bodCnt = 6'h00;
      end
      bodTrip = brownoutEnable & brownoutLow & (s_q.bodCnt >= BodMin);
      extTrip = ~extResetPin_b & ~extResetDisableFuse;
      srcActive = porLow | extTrip | bodTrip | s_q.wdPulse;
      sysReset = srcActive | s_q.delayBusy;

      effRe = watchdogAlwaysOnFuse | s_q.resetEn | s_q.rstFlags[`WDRS_FLAG_WD];
      effIe = s_q.irqEn & ~watchdogAlwaysOnFuse;
      running = effRe | effIe;
      // Reserved prescale codes fall back to the longest period.
      code = (s_q.prescale > `WDRS_WD_MAX_CODE) ? `WDRS_WD_MAX_CODE : s_q.prescale;
      limit = 21'(`WDRS_WD_BASE_CYCLES) << code;
      // The comparison is >= so a switch to a shorter period expires on the next oscillator tick.
      expire = running & tick & ~sysReset & (s_q.wdCount >= limit - 21'h00_0001);
      // No sleep input exists: counting never pauses while enabled.
      if (wdRestart || !running || expire || sysReset) begin
         s_d.wdCount = 21'h00_0000;
      end else if (tick) begin
         s_d.wdCount = s_q.wdCount + 21'h00_0001;
      end
      // A pending interrupt at expiry in combined mode means the handler never ran.
      resetReq = expire & effRe & (~effIe | s_q.irqFlag);
      s_d.wdPulse = resetReq;

      if (srcActive) begin
         s_d.delayCnt = 20'h0_0000;
         s_d.delayBusy = 1'b1;
      end else if (s_q.delayBusy) begin
         s_d.delayCnt = s_q.delayCnt + 20'h0_0001;
         s_d.delayBusy = (s_q.delayCnt != DelayLast);
      end

      if (porLow) begin
         s_d.rstFlags = `WDRS_FLAGS_RESET;
      end else begin
         if (wr && addr == `WDRS_ADDR_FLAGS) begin
            s_d.rstFlags = s_q.rstFlags & wdata[3:0];
         end
         s_d.rstFlags[`WDRS_FLAG_EXT] = s_d.rstFlags[`WDRS_FLAG_EXT] | extTrip;
         s_d.rstFlags[`WDRS_FLAG_BOD] = s_d.rstFlags[`WDRS_FLAG_BOD] | bodTrip;
         s_d.rstFlags[`WDRS_FLAG_WD] = s_d.rstFlags[`WDRS_FLAG_WD] | resetReq;
      end

      ctrlWr = wr & (addr == `WDRS_ADDR_CTRL);
      if (sysReset) begin
         s_d.irqFlag = 1'b0;
         s_d.irqEn = 1'b0;
         s_d.resetEn = 1'b0;
         s_d.prescale = 4'h0;
         s_d.unlockCnt = 3'h0;
         s_d.cmpBandgapSel = 1'b0;
      end else begin
         if (s_q.unlockCnt != 3'h0) begin
            s_d.unlockCnt = s_q.unlockCnt - 3'h1;
         end
         if (ctrlWr) begin
            s_d.irqEn = wdata[`WDRS_CTRL_IE];
            if (wdata[`WDRS_CTRL_CE] && wdata[`WDRS_CTRL_RE]) begin
               s_d.unlockCnt = `WDRS_UNLOCK_CYCLES;
               s_d.resetEn = 1'b1;
            end else if (s_q.unlockCnt != 3'h0 && !wdata[`WDRS_CTRL_CE]) begin
               s_d.resetEn = wdata[`WDRS_CTRL_RE];
               s_d.prescale = {wdata[`WDRS_CTRL_P3], wdata[2:0]};
               s_d.unlockCnt = 3'h0;
            end else begin
               s_d.resetEn = s_q.resetEn | wdata[`WDRS_CTRL_RE];
            end
            if (wdata[`WDRS_CTRL_IF]) begin
               s_d.irqFlag = 1'b0;
            end
         end
         if (irqAck) begin
            s_d.irqFlag = 1'b0;
            if (effRe && s_q.irqEn) begin
               s_d.irqEn = 1'b0;
            end
         end
         // A time-out in the clearing cycle still lands.
         s_d.irqFlag = s_d.irqFlag | (expire & effIe);
         if (wr && addr == `WDRS_ADDR_CMP) begin
            s_d.cmpBandgapSel = wdata[`WDRS_CMP_BG];
         end
      end
      s_d.bandgapEn = brownoutEnable | s_q.cmpBandgapSel | adcEnable;

      s_d.rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            `WDRS_ADDR_CTRL: s_d.rdata = {s_q.irqFlag, effIe, s_q.prescale[3], s_q.unlockCnt != 3'h0,
                                           effRe, s_q.prescale[2:0]};
            `WDRS_ADDR_FLAGS: s_d.rdata = {4'h0, s_q.rstFlags};
            `WDRS_ADDR_CMP: s_d.rdata = {7'h00, s_q.cmpBandgapSel};
            default: s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.rstFlags <= `WDRS_FLAGS_RESET;
         s_q.delayBusy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign wdIrq = s_q.irqFlag & effIe;
   assign bandgapEnable = s_q.bandgapEn;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   por_reset_a: assert property (porLow |-> sysReset ##1 s_q.delayBusy)
      else $error("power-on low did not hold reset");
   ext_pin_a: assert property (extTrip |-> sysReset ##1 (s_q.delayBusy && s_q.delayCnt == 20'h0_0000))
      else $error("external pin low did not reset");
   ext_disable_a: assert property ($rose(s_q.rstFlags[`WDRS_FLAG_EXT]) |-> !$past(extResetDisableFuse))
      else $error("external reset taken while disabled");
   bod_filter_a: assert property (!(brownoutEnable && brownoutLow) ##1 (brownoutEnable && brownoutLow)
      |-> !bodTrip)
      else $error("brown-out glitch caused reset");
   bod_trip_a: assert property ((brownoutEnable && brownoutLow && s_q.bodCnt == BodMin) |-> sysReset)
      else $error("lasting brown-out did not reset");
   wd_pulse_a: assert property (s_q.wdPulse |=> !s_q.wdPulse && s_q.delayBusy && s_q.delayCnt == 20'h0_0000)
      else $error("watchdog reset pulse wrong");
   bandgap_en_a: assert property (##1 bandgapEnable == $past(brownoutEnable || s_q.cmpBandgapSel || adcEnable))
      else $error("bandgap enable mismatch");
   restart_clr_a: assert property (wdRestart |=> s_q.wdCount == 21'h00_0000)
      else $error("restart did not clear counter");
   irq_set_a: assert property ((expire && effIe) |=> s_q.irqFlag)
      else $error("expiry did not set interrupt flag");
   reset_mode_a: assert property ((expire && effRe && !effIe) |=> s_q.wdPulse)
      else $error("expiry in reset mode did not reset");
   combined_ack_a: assert property ((irqAck && effRe && s_q.irqEn && !sysReset && !ctrlWr) |=> !s_q.irqEn)
      else $error("vector service kept interrupt enable");
   always_on_a: assert property (watchdogAlwaysOnFuse |-> effRe && !effIe && !wdIrq)
      else $error("always-on fuse not forcing reset mode");
   flag_force_a: assert property (s_q.rstFlags[`WDRS_FLAG_WD] |-> effRe)
      else $error("reset flag did not force reset enable");
   unlock_close_a: assert property ((s_q.unlockCnt == 3'h1 && !ctrlWr) |=> s_q.unlockCnt == 3'h0)
      else $error("change enable did not close");
   no_window_a: assert property ((ctrlWr && s_q.unlockCnt == 3'h0 && !sysReset) |=> $stable(s_q.prescale))
      else $error("prescale changed outside window");
   delay_end_a: assert property ((!srcActive && s_q.delayBusy && s_q.delayCnt == DelayLast) |=> !s_q.delayBusy)
      else $error("delay did not release reset");

   // Reset-flag bookkeeping: each source leaves its mark, and power-on wipes the rest.
   por_flags_a: assert property (porLow |=> s_q.rstFlags == `WDRS_FLAGS_RESET)
      else $error("power-on did not reset the flags");
   ext_flag_a: assert property ((extTrip && !porLow) |=> s_q.rstFlags[`WDRS_FLAG_EXT])
      else $error("external reset flag not set");
   bod_flag_a: assert property ((bodTrip && !porLow) |=> s_q.rstFlags[`WDRS_FLAG_BOD])
      else $error("brown-out flag not set");
   flag_clear_a: assert property ((wr && addr == `WDRS_ADDR_FLAGS && !srcActive && !resetReq)
      |=> s_q.rstFlags == ($past(s_q.rstFlags) & $past(wdata[3:0])))
      else $error("flag write did not clear");

   // Each source that goes quiet hands over to a delay that starts from zero.
   ext_release_a: assert property ($fell(extTrip) |-> s_q.delayBusy && s_q.delayCnt == 20'h0_0000)
      else $error("external release skipped the delay");
   bod_release_a: assert property ($fell(bodTrip) |-> s_q.delayBusy && s_q.delayCnt == 20'h0_0000)
      else $error("brown-out release skipped the delay");
   delay_count_a: assert property ((!srcActive && s_q.delayBusy && s_q.delayCnt != DelayLast)
      |=> s_q.delayBusy && s_q.delayCnt == $past(s_q.delayCnt) + 20'h0_0001)
      else $error("delay counter did not advance");

   // The synchroniser may show a false edge right after reset, which is harmless while reset still holds.
   sync_tick_a: assert property ((tick && !sysReset) |-> $past(wdOscClk, 2) && !$past(wdOscClk, 3))
      else $error("oscillator edge not synchronised");
   count_step_a: assert property ((tick && running && !wdRestart && !expire && !sysReset)
      |=> s_q.wdCount == $past(s_q.wdCount) + 21'h00_0001)
      else $error("watchdog counter missed a tick");
   count_hold_a: assert property ((!tick && running && !wdRestart && !sysReset) |=> $stable(s_q.wdCount))
      else $error("watchdog counter moved without a tick");
   stopped_clear_a: assert property (!running |=> s_q.wdCount == 21'h00_0000)
      else $error("stopped watchdog kept its count");
   irq_only_a: assert property ((expire && effIe && !effRe) |=> !s_q.wdPulse)
      else $error("interrupt mode expiry reset the device");
   wd_flag_a: assert property (resetReq |=> s_q.wdPulse && s_q.rstFlags[`WDRS_FLAG_WD])
      else $error("watchdog reset flag not set");
   combined_first_a: assert property ((expire && effRe && effIe && !s_q.irqFlag)
      |=> s_q.irqFlag && !s_q.wdPulse)
      else $error("combined mode reset on first expiry");
   fuse_reset_a: assert property ((expire && watchdogAlwaysOnFuse) |=> s_q.wdPulse)
      else $error("always-on fuse expiry did not reset");
   wd_stays_a: assert property ((s_q.wdPulse && !wr && !porLow) |=> effRe)
      else $error("watchdog disabled by its own reset");

   // Protected sequence: the unlock opens a four-cycle window, and a plain write loads and closes it.
   unlock_open_a: assert property ((ctrlWr && wdata[`WDRS_CTRL_CE] && wdata[`WDRS_CTRL_RE] && !sysReset)
      |=> s_q.unlockCnt == `WDRS_UNLOCK_CYCLES && s_q.resetEn)
      else $error("unlock did not open the window");
   window_load_a: assert property ((ctrlWr && s_q.unlockCnt != 3'h0 && !wdata[`WDRS_CTRL_CE] && !sysReset)
      |=> s_q.resetEn == $past(wdata[`WDRS_CTRL_RE]) && s_q.unlockCnt == 3'h0
         && s_q.prescale == {$past(wdata[`WDRS_CTRL_P3]), $past(wdata[2:0])})
      else $error("window write not loaded");
   re_sticky_a: assert property ((ctrlWr && s_q.unlockCnt == 3'h0 && s_q.resetEn && !sysReset)
      |=> s_q.resetEn)
      else $error("reset enable cleared outside window");
   irq_ack_a: assert property ((irqAck && !(expire && effIe)) |=> !s_q.irqFlag)
      else $error("vector service kept the interrupt flag");
   rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside the read answer");

   wd_reset_c: cover property (s_q.wdPulse ##1 s_q.delayBusy);
   wd_irq_c: cover property ($rose(s_q.irqFlag));
   unlock_change_c: cover property (s_q.unlockCnt == 3'h4 ##[1:3] $changed(s_q.prescale));
   bod_reset_c: cover property ($rose(bodTrip));
   window_close_c: cover property (s_q.unlockCnt == 3'h1 ##1 s_q.unlockCnt == 3'h0);

endmodule : wdrs_watchdog_and_reset_sequencer

`default_nettype wire

// *** tb/tb_wdrs_watchdog_and_reset_sequencer.sv ***
// Self-checking bench for the watchdog and reset sequencer, with a register-level model held in the bench.
// Assumes logic/ is compiled first; the reset delay is shortened so each reset costs only a few cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_wdrs_watchdog_and_reset_sequencer;
   localparam int Dly = 12;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic porLow = 1'b0;
   logic extResetPin_b = 1'b1;
   logic extResetDisableFuse = 1'b0;
   logic brownoutEnable = 1'b0;
   logic brownoutLow = 1'b0;
   logic watchdogAlwaysOnFuse = 1'b0;
   logic adcEnable = 1'b0;
   logic wdOscClk = 1'b0;
   logic wdRestart = 1'b0;
   logic irqAck = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic sysReset;
   logic wdIrq;
   logic bandgapEnable;
   logic mIf = 1'b0;
   logic mIe = 1'b0;
   logic mRe = 1'b0;
   logic [3:0] mPs = 4'h0;
   logic [3:0] mFlags = 4'h1;
   int errors = 0;
   int nCompared = 0;
   int rstCyc = 0;
   int g;

   wdrs_watchdog_and_reset_sequencer #(.DelayCycles(Dly)) i_wdrs_watchdog_and_reset_sequencer (
      .clk(clk), .rst_b(rst_b), .porLow(porLow), .extResetPin_b(extResetPin_b),
      .extResetDisableFuse(extResetDisableFuse), .brownoutEnable(brownoutEnable), .brownoutLow(brownoutLow),
      .watchdogAlwaysOnFuse(watchdogAlwaysOnFuse), .adcEnable(adcEnable), .wdOscClk(wdOscClk),
      .wdRestart(wdRestart), .irqAck(irqAck), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .sysReset(sysReset), .wdIrq(wdIrq), .bandgapEnable(bandgapEnable));

   always #25 clk = ~clk;
   always @(posedge clk) if (sysReset === 1'b1) rstCyc <= rstCyc + 1;

   // The forced reset-enable reflects the fuse and the pending watchdog reset flag, not only the stored bit.
   function automatic logic [7:0] ctrlExp(input logic ce);
      return {mIf, mIe & ~watchdogAlwaysOnFuse, mPs[3], ce, mRe | watchdogAlwaysOnFuse | mFlags[3], mPs[2:0]};
   endfunction : ctrlExp

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic chk1(input string what, input logic seen, input logic exp);
      chk(what, {7'h00, seen}, {7'h00, exp});
   endtask : chk1

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
      end
      @(posedge clk) wr <= 1'b0;
   endtask : wr8

   task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge clk) begin
         addr <= a;
         rd <= 1'b1;
      end
      @(posedge clk) rd <= 1'b0;
      #1 chk(what, rdata, e);
   endtask : rdChk

   task automatic strobe(input bit ackIt);
      @(posedge clk) if (ackIt) irqAck <= 1'b1; else wdRestart <= 1'b1;
      @(posedge clk) begin
         irqAck <= 1'b0;
         wdRestart <= 1'b0;
      end
   endtask : strobe

   // Oscillator edges four clocks apart, well below half the system clock, plus time for the synchroniser.
   task automatic osc(input int n);
      repeat (n) begin
         @(posedge clk) wdOscClk <= 1'b1;
         @(posedge clk);
         @(posedge clk) wdOscClk <= 1'b0;
         @(posedge clk);
      end
      cyc(4);
   endtask : osc

   task automatic waitRel(input string what);
      int n;
      n = 0;
      while (sysReset !== 1'b0 && n < 200) begin
         @(posedge clk);
         #1 n++;
      end
      chk1(what, n >= Dly && n <= Dly + 3, 1'b1);
   endtask : waitRel

   task wrap_up;
      $display("Compared %0d, mismatches %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      wrap_up;
   end

   initial begin
      g = $urandom(53076);
      cyc(3);
      rst_b <= 1'b1;
      waitRel("reset release");
      rdChk(8'h01, {4'h0, mFlags}, "flags after reset");
      rdChk(8'h07, 8'h00, "unmapped read");
      wr8(8'h01, 8'h00);
      mFlags = 4'h0;
      @(posedge clk) porLow <= 1'b1;
      #1 chk1("power low at once", sysReset, 1'b1);
      @(posedge clk) porLow <= 1'b0;
      waitRel("power release");
      mFlags = 4'h1;
      @(posedge clk) begin
         extResetDisableFuse <= 1'b1;
         extResetPin_b <= 1'b0;
      end
      cyc(5);
      #1 chk1("pin ignored", sysReset, 1'b0);
      @(posedge clk) extResetDisableFuse <= 1'b0;
      cyc(5);
      #1 chk1("pin resets", sysReset, 1'b1);
      @(posedge clk) extResetPin_b <= 1'b1;
      waitRel("pin release");
      mFlags[1] = 1'b1;
      g = 1 + $urandom % 30;
      @(posedge clk) begin
         brownoutEnable <= 1'b1;
         brownoutLow <= 1'b1;
      end
      cyc(g);
      @(posedge clk) brownoutLow <= 1'b0;
      cyc(3);
      #1 chk1("glitch ignored", sysReset, 1'b0);
      @(posedge clk) brownoutLow <= 1'b1;
      cyc(50);
      #1 chk1("brown-out resets", sysReset, 1'b1);
      @(posedge clk) brownoutLow <= 1'b0;
      waitRel("brown-out release");
      mFlags[2] = 1'b1;
      rdChk(8'h01, {4'h0, mFlags}, "source flags");
      wr8(8'h01, 8'h00);
      mFlags = 4'h0;
      $display("Test reset sources done");
      for (int i = 0; i < 8; i++) begin
         wr8(8'h02, {7'h00, i[0]});
         @(posedge clk) begin
            brownoutEnable <= i[1];
            adcEnable <= i[2];
         end
         cyc(2);
         #1 chk1("bandgap", bandgapEnable, |i[2:0]);
         rdChk(8'h02, {7'h00, i[0]}, "comparator reg");
      end
      $display("Test bandgap done");
      wr8(8'h00, 8'h08);
      mRe = 1'b1;
      rdChk(8'h00, ctrlExp(1'b0), "enable set");
      wr8(8'h00, 8'h00);
      rdChk(8'h00, ctrlExp(1'b0), "clear refused");
      wr8(8'h00, 8'h18);
      rdChk(8'h00, ctrlExp(1'b1), "unlock open");
      cyc(6);
      wr8(8'h00, 8'h05);
      rdChk(8'h00, ctrlExp(1'b0), "window closed");
      wr8(8'h00, 8'h18);
      wr8(8'h00, 8'h21);
      mRe = 1'b0;
      mPs = 4'h9;
      rdChk(8'h00, ctrlExp(1'b0), "protected change");
      strobe(1'b0);
      wr8(8'h00, 8'h18);
      wr8(8'h00, 8'h00);
      mPs = 4'h0;
      rdChk(8'h00, ctrlExp(1'b0), "shortest period");
      $display("Test protected change done");
      wr8(8'h00, 8'h40);
      mIe = 1'b1;
      strobe(1'b0);
      osc(2000);
      strobe(1'b0);
      osc(2000);
      #1 chk1("restart holds off", wdIrq, 1'b0);
      osc(60);
      mIf = 1'b1;
      #1 chk1("interrupt on expiry", wdIrq, 1'b1);
      rdChk(8'h00, ctrlExp(1'b0), "irq flag set");
      strobe(1'b1);
      mIf = 1'b0;
      rdChk(8'h00, ctrlExp(1'b0), "irq serviced");
      chk1("irq dropped", wdIrq, 1'b0);
      osc(2040);
      mIf = 1'b1;
      #1 chk1("second expiry", wdIrq, 1'b1);
      wr8(8'h00, 8'hC0);
      mIf = 1'b0;
      rdChk(8'h00, ctrlExp(1'b0), "flag written clear");
      wr8(8'h00, 8'h48);
      mRe = 1'b1;
      strobe(1'b0);
      osc(2060);
      mIf = 1'b1;
      #1 chk1("combined first irq", wdIrq, 1'b1);
      strobe(1'b1);
      mIf = 1'b0;
      mIe = 1'b0;
      rdChk(8'h00, ctrlExp(1'b0), "combined to reset");
      rstCyc = 0;
      osc(2060);
      chk1("single watchdog reset", rstCyc >= Dly + 1 && rstCyc <= Dly + 3, 1'b1);
      mRe = 1'b0;
      mFlags = 4'h8;
      rdChk(8'h01, {4'h0, mFlags}, "watchdog flag");
      rdChk(8'h00, ctrlExp(1'b0), "still enabled");
      wr8(8'h00, 8'h18);
      wr8(8'h00, 8'h00);
      rdChk(8'h00, ctrlExp(1'b0), "flag holds enable");
      wr8(8'h01, 8'h00);
      mFlags = 4'h0;
      rdChk(8'h00, ctrlExp(1'b0), "enable free");
      @(posedge clk) watchdogAlwaysOnFuse <= 1'b1;
      wr8(8'h00, 8'h40);
      mIe = 1'b1;
      rdChk(8'h00, ctrlExp(1'b0), "fuse forces mode");
      $display("Test watchdog done");
      wrap_up;
   end
endmodule : tb_wdrs_watchdog_and_reset_sequencer

`default_nettype wire
